// ### rtl/vme_jtag_chains.sv
`timescale 1ns/1ns
module vme_jtag_chains
    import jtag_chain_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     tck,
    input  wire logic                     bus_sel,
    input  wire logic                     bus_write,
    input  wire jtag_chain_pkg::reg_idx_t bus_addr,
    input  wire jtag_chain_pkg::word_t    bus_data_word,
    output jtag_chain_pkg::word_t         bus_rdata,
    output logic                          bus_ack,
    output jtag_chain_pkg::word_t         chain_mode_pin,
    output jtag_chain_pkg::word_t         chain_in_pin,
    input  wire jtag_chain_pkg::word_t    chain_out_pin
);
    import jtag_chain_pkg::*;

    localparam int RT_MIN = `ROUND_TRIP_MIN;
    localparam int RT_MAX = `ROUND_TRIP_MAX;

    // ****************************************************************
    // Registers, in bus order
    // ****************************************************************
    word_t       chain_mode_select_r;
    word_t       chain_serial_in_r;
    word_t       chain_serial_out_r;
    word_t       bus_rdata_r;
    logic        bus_ack_r;
    logic        wr_hit;
    logic        rd_hit;

    chain_link_if lnk ();

    // Selects decoded once; all four slices move on the same access
    assign wr_hit = ce && bus_sel && bus_write;
    assign rd_hit = ce && bus_sel && !bus_write;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_mode_select_r <= `WORD_RESET;
        end else if (wr_hit && bus_addr == `REG_MODE_SEL) begin
            chain_mode_select_r <= bus_data_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_serial_in_r <= `WORD_RESET;
        end else if (wr_hit && bus_addr == `REG_SERIAL_IN) begin
            chain_serial_in_r <= bus_data_word;
        end
    end

    // Unmapped select reads zero; data-out ignores writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata_r <= `WORD_RESET;
        end else if (rd_hit) begin
            unique case (bus_addr)
                `REG_MODE_SEL:   bus_rdata_r <= chain_mode_select_r;
                `REG_SERIAL_IN:  bus_rdata_r <= chain_serial_in_r;
                `REG_SERIAL_OUT: bus_rdata_r <= chain_serial_out_r;
                default:         bus_rdata_r <= `WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack_r <= 1'b0;
        end else if (ce) begin
            bus_ack_r <= bus_sel;
        end
    end

    assign bus_rdata = bus_rdata_r;
    assign bus_ack   = bus_ack_r;

    // ****************************************************************
    // Transfer to the link clock
    // ****************************************************************
    // A handshake round runs back to back forever, so the pins follow
    // the registers and data-out refreshes within one round trip.
    // Trade-off: a write lands one round late at worst, never torn.
    link_state_e state_r;
    logic        req_r;
    word_t       mode_link_r;
    word_t       in_link_r;
    logic        ack_s1_r;
    logic        ack_s2_r;
    logic        ack_s3_r;
    logic        done;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else if (ce) begin
            ack_s1_r <= lnk.ack_tgl;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    assign done = ack_s2_r ^ ack_s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LINK_IDLE;
        end else if (ce) begin
            unique case (state_r)
                LINK_IDLE: state_r <= LINK_WAIT;
                LINK_WAIT: begin
                    if (done) begin
                        state_r <= LINK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r       <= 1'b0;
            mode_link_r <= `WORD_RESET;
            in_link_r   <= `WORD_RESET;
        end else if (ce && state_r == LINK_IDLE) begin
            req_r       <= ~req_r;
            mode_link_r <= swap_slices(chain_mode_select_r);
            in_link_r   <= swap_slices(chain_serial_in_r);
        end
    end

    // Snapshot is stable in the link domain while we wait for the ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_serial_out_r <= `WORD_RESET;
        end else if (ce && state_r == LINK_WAIT && done) begin
            chain_serial_out_r <= swap_slices(lnk.out_snap);
        end
    end

    assign lnk.req_tgl     = req_r;
    assign lnk.mode_word   = mode_link_r;
    assign lnk.serial_word = in_link_r;

    chain_link_drive u_drive (
        .tck            (tck),
        .rst_n          (rst_n),
        .lnk            (lnk.link),
        .chain_out_pin  (chain_out_pin),
        .chain_mode_pin (chain_mode_pin),
        .chain_in_pin   (chain_in_pin)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    mode_wr_a: assert property (wr_hit && bus_addr == `REG_MODE_SEL |=>
        chain_mode_select_r == $past(bus_data_word) && bus_ack_r)
        else $error("mode select write not taken");
    slice_map_a: assert property (state_r == LINK_IDLE |=>
        mode_link_r[7:0] == $past(chain_mode_select_r[31:24]) &&
        mode_link_r[31:24] == $past(chain_mode_select_r[7:0]))
        else $error("mezzanine slice order wrong");
    chain_bit_a: assert property (state_r == LINK_IDLE |=>
        in_link_r[15:8] == $past(chain_serial_in_r[23:16]) &&
        in_link_r[16] == $past(chain_serial_in_r[8]))
        else $error("chain bit order wrong");
    readback_a: assert property (rd_hit && bus_addr == `REG_SERIAL_OUT |=>
        bus_rdata_r == $past(chain_serial_out_r) && bus_ack_r)
        else $error("data-out read wrong");
    round_trip_a: assert property ($rose(state_r == LINK_WAIT) |->
        ##[RT_MIN:RT_MAX] state_r == LINK_IDLE)
        else $error("link round trip too slow or too fast");

    write_in_c: cover property (wr_hit && bus_addr == `REG_SERIAL_IN);
    read_out_c: cover property (rd_hit && bus_addr == `REG_SERIAL_OUT);
    round_c:    cover property (state_r == LINK_WAIT && done);
endmodule // vme_jtag_chains

// ### rtl/jtag_chain_map.svh
`ifndef JTAG_CHAIN_MAP_SVH
`define JTAG_CHAIN_MAP_SVH

// ****************************************************************
// Register selects and layout
// ****************************************************************
`define REG_MODE_SEL    2'h0
`define REG_SERIAL_IN   2'h1
`define REG_SERIAL_OUT  2'h2
`define WORD_RESET      32'h0000_0000
`define CHAIN_COUNT     32
`define MEZZ_COUNT      4
`define SLICE_W         8
`define CHIPS_PER_CHAIN 2

// ****************************************************************
// Instruction codes of the chips on each chain
// ****************************************************************
`define IR_BYPASS       8'hFF
`define IR_IDCODE       8'h01
`define IR_PATT_DATA_WR 8'hC5
`define IR_PATT_DATA_RD 8'hE5
`define IR_PATT_ADDR_WR 8'hC4
`define IR_PATT_ADDR_RD 8'hE4
`define IR_PATT_CTRL_WR 8'hC6
`define IR_PATT_CTRL_RD 8'hE6
`define IR_BANK_STATUS  8'hE8
`define IR_SER_SELECT   8'hC9
`define IR_SER_WRITE    8'hCA
`define IR_IDLE_CFG     8'hCB
`define IR_SER_INFO     8'hEA
`define IR_CRC_READ     8'hED
`define IR_PATT_TEST    8'hCD
`define IR_WRITE_ADV    8'hD4
`define IR_NEXT_PATT    8'hD5
`define IR_INIT_EVENT   8'hD6

// ****************************************************************
// Handshake timing, in system clock cycles
// ****************************************************************
`define ROUND_TRIP_MIN  3
`define ROUND_TRIP_MAX  40

`endif

// ### rtl/jtag_chain_pkg.sv
package jtag_chain_pkg;
    `include "jtag_chain_map.svh"

    typedef logic [`CHAIN_COUNT-1:0] word_t;
    typedef logic [1:0]              reg_idx_t;
    typedef enum logic [0:0] {LINK_IDLE, LINK_WAIT} link_state_e;

    // Bus order to pin order: pin m*8+n is bus bit (3-m)*8+n.
    // The map is its own inverse, so one function serves both ways.
    function automatic word_t swap_slices(input word_t w);
        word_t r;
        r = '0;
        for (int m = 0; m < `MEZZ_COUNT; m++) begin
            for (int n = 0; n < `SLICE_W; n++) begin
                r[m*`SLICE_W+n] = w[(`MEZZ_COUNT-1-m)*`SLICE_W+n];
            end
        end
        return r;
    endfunction
endpackage

// ### rtl/chain_link_if.sv
`timescale 1ns/1ns
interface chain_link_if;
    import jtag_chain_pkg::*;
    logic  req_tgl;
    word_t mode_word;
    word_t serial_word;
    logic  ack_tgl;
    word_t out_snap;

    modport ctl  (output req_tgl, mode_word, serial_word,
                  input  ack_tgl, out_snap);
    modport link (input  req_tgl, mode_word, serial_word,
                  output ack_tgl, out_snap);
endinterface // chain_link_if

// ### rtl/chain_link_drive.sv
`timescale 1ns/1ns
module chain_link_drive
    import jtag_chain_pkg::*;
(
    input  wire logic           tck,
    input  wire logic           rst_n,
    chain_link_if.link          lnk,
    input  wire jtag_chain_pkg::word_t chain_out_pin,
    output jtag_chain_pkg::word_t      chain_mode_pin,
    output jtag_chain_pkg::word_t      chain_in_pin
);
    import jtag_chain_pkg::*;

    // ****************************************************************
    // Synchronisers on the link clock
    // ****************************************************************
    word_t out_s1_r;
    word_t out_s2_r;
    logic  req_s1_r;
    logic  req_s2_r;
    logic  req_s3_r;
    logic  ack_r;
    word_t snap_r;
    word_t mode_q_r;
    word_t in_q_r;
    logic  take;

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            out_s1_r <= `WORD_RESET;
            out_s2_r <= `WORD_RESET;
        end else begin
            out_s1_r <= chain_out_pin;
            out_s2_r <= out_s1_r;
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= lnk.req_tgl;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    assign take = req_s2_r ^ req_s3_r;

    // ****************************************************************
    // Pin update and output capture
    // ****************************************************************
    // Words are held stable by the sender until the ack returns
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            mode_q_r <= `WORD_RESET;
            in_q_r   <= `WORD_RESET;
        end else if (take) begin
            mode_q_r <= lnk.mode_word;
            in_q_r   <= lnk.serial_word;
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= `WORD_RESET;
            ack_r  <= 1'b0;
        end else if (take) begin
            snap_r <= out_s2_r;
            ack_r  <= ~ack_r;
        end
    end

    assign chain_mode_pin = mode_q_r;
    assign chain_in_pin   = in_q_r;
    assign lnk.ack_tgl    = ack_r;
    assign lnk.out_snap   = snap_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge tck); endclocking
    default disable iff (!rst_n);

    all_update_a: assert property (take |=>
        in_q_r == $past(lnk.serial_word) && mode_q_r == $past(lnk.mode_word))
        else $error("chain pins not all updated together");
    pin_hold_a: assert property (!take |=>
        $stable(in_q_r) && $stable(mode_q_r))
        else $error("chain pins moved without a transfer");
    snap_a: assert property (take |=>
        snap_r == $past(out_s2_r) && ack_r != $past(ack_r))
        else $error("chain output snapshot wrong");
    pins_moved_c: cover property (take ##1 $changed(in_q_r));
endmodule // chain_link_drive

// ### bench/chain_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Far side: thirty-two two-chip chains, one line of each per bit
// ****************************************************************
module chain_model
    import jtag_chain_pkg::*;
(
    input  wire jtag_chain_pkg::word_t chain_mode_pin,
    input  wire jtag_chain_pkg::word_t chain_in_pin,
    output jtag_chain_pkg::word_t      chain_out_pin
);
    import jtag_chain_pkg::*;

    // Each chain answers on its own bit only, never on a neighbour's
    // Mixing mode into the answer makes a swapped mode pin visible too
    always_comb begin
        chain_out_pin = chain_in_pin ^ chain_mode_pin;
    end
endmodule // chain_model

// ### bench/vme_parallel_jtag_chain_driver_test.sv
`timescale 1ns/1ns
module vme_parallel_jtag_chain_driver_test;
    import jtag_chain_pkg::*;

    logic     clk;
    logic     tck;
    logic     rst_n;
    logic     ce;
    logic     bus_sel;
    logic     bus_write;
    reg_idx_t bus_addr;
    word_t    bus_data_word;
    word_t    bus_rdata;
    logic     bus_ack;
    word_t    chain_mode_pin;
    word_t    chain_in_pin;
    word_t    chain_out_pin;
    int       bad_count;
    int       checks;
    int       cycles;
    word_t    md;
    word_t    sd;
    word_t    q;
    logic     ack;

    vme_jtag_chains u_vme_jtag_chains (
        .clk           (clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .tck           (tck),
        .bus_sel       (bus_sel),
        .bus_write     (bus_write),
        .bus_addr      (bus_addr),
        .bus_data_word (bus_data_word),
        .bus_rdata     (bus_rdata),
        .bus_ack       (bus_ack),
        .chain_mode_pin(chain_mode_pin),
        .chain_in_pin  (chain_in_pin),
        .chain_out_pin (chain_out_pin)
    );

    chain_model u_chain_model (
        .chain_mode_pin(chain_mode_pin),
        .chain_in_pin  (chain_in_pin),
        .chain_out_pin (chain_out_pin)
    );

    always #5 clk = ~clk;
    always #6 tck = ~tck;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string what, input word_t seen,
                         input word_t exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bus order to pin order, worked out independently by byte reversal
    function automatic word_t to_pins(input word_t w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    task automatic access(input logic wr, input reg_idx_t a,
                          input word_t d);
        @(negedge clk);
        bus_sel = 1'b1;
        bus_write = wr;
        bus_addr = a;
        bus_data_word = d;
        @(negedge clk);
        bus_sel = 1'b0;
        ack = bus_ack;
        q = bus_rdata;
    endtask

    task automatic wr(input reg_idx_t a, input word_t d);
        access(1'b1, a, d);
        check("write ack", {31'h0, ack}, 32'h0000_0001);
    endtask

    task automatic rd_chk(input reg_idx_t a, input word_t exp,
                          input string what);
        access(1'b0, a, 32'h0000_0000);
        check("read ack", {31'h0, ack}, 32'h0000_0001);
        check(what, q, exp);
    endtask

    // One instruction code on every chain at once, low bit first
    task automatic shift_code(input logic [7:0] code);
        for (int b = 0; b < 8; b++) begin
            wr(2'h1, {32{code[b]}});
            repeat (80) @(negedge clk);
            check("code bit pins", chain_in_pin, {32{code[b]}});
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run needs about 12000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        tck = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        bus_sel = 1'b0;
        bus_write = 1'b0;
        bus_addr = 2'h0;
        bus_data_word = 32'h0000_0000;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check("mode pins at reset", chain_mode_pin, 32'h0);
        check("in pins at reset", chain_in_pin, 32'h0);
        for (int a = 0; a < 4; a++) begin
            rd_chk(reg_idx_t'(a), 32'h0000_0000, "reset read");
        end
        // One write moves every chain of every mezzanine together
        md = 32'hA5C3_0F81;
        sd = 32'h8001_7E24;
        wr(2'h0, md);
        wr(2'h1, sd);
        rd_chk(2'h0, md, "mode readback");
        rd_chk(2'h1, sd, "serial in readback");
        repeat (100) @(negedge clk);
        check("mode pins", chain_mode_pin, to_pins(md));
        check("in pins", chain_in_pin, to_pins(sd));
        rd_chk(2'h2, md ^ sd, "serial out");
        // Read-only and unmapped places refuse writes
        wr(2'h2, 32'hFFFF_FFFF);
        wr(2'h3, 32'hFFFF_FFFF);
        rd_chk(2'h3, 32'h0000_0000, "unmapped read");
        rd_chk(2'h0, md, "mode kept");
        rd_chk(2'h1, sd, "serial in kept");
        // Clock enable low: access not taken at all
        @(negedge clk);
        ce = 1'b0;
        access(1'b1, 2'h1, 32'h1234_5678);
        check("ack with ce low", {31'h0, ack}, 32'h0);
        ce = 1'b1;
        rd_chk(2'h1, sd, "serial in frozen");
        // Walking one over every bus bit, one chain at a time
        wr(2'h0, 32'h0000_0000);
        for (int k = 0; k < 32; k++) begin
            wr(2'h1, 32'h0000_0001 << k);
            repeat (100) @(negedge clk);
            check("walking in pin", chain_in_pin,
                  32'h0000_0001 << ((3 - k / 8) * 8 + k % 8));
            check("walking mode pin", chain_mode_pin, 32'h0);
            rd_chk(2'h2, 32'h0000_0001 << k, "walking out");
        end
        // Controller traffic: instruction codes broadcast to all chains
        shift_code(`IR_BYPASS);
        shift_code(`IR_IDCODE);
        shift_code(`IR_PATT_DATA_WR);
        shift_code(`IR_PATT_ADDR_WR);
        shift_code(`IR_PATT_CTRL_WR);
        shift_code(`IR_SER_SELECT);
        shift_code(`IR_SER_WRITE);
        shift_code(`IR_SER_INFO);
        shift_code(`IR_CRC_READ);
        shift_code(`IR_PATT_TEST);
        shift_code(`IR_WRITE_ADV);
        shift_code(`IR_NEXT_PATT);
        shift_code(`IR_INIT_EVENT);
        report_and_stop();
    end
endmodule // vme_parallel_jtag_chain_driver_test
